// ### logic/cprc_pkg.sv
// Purpose: shared constants for the configuration memory reset control and its target end
// Assumes: 100 MHz MCLK
// Notes: times in ns, cycle counts derived from them
package cprc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RELEASE_HOLD_NS = 2000; // release_hold_delay minimum, plain default
   localparam int RELEASE_HOLD_CYC = (RELEASE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CFG_PULSE_NS = 300; // config_pulse_n low time
   localparam int CFG_PULSE_CYC = (CFG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLK_DIV_HALF = 8; // prom_clock_out half period in MCLK cycles
   // ---------------------------------------------------------------
   // data and address
   // ---------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
   localparam logic [ADDR_W-1:0] TERM_COUNT = 16'hFFFF;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   typedef logic [DATA_W-1:0] cprc_data_t;
endpackage : cprc_pkg

// ### logic/cprc_if.sv
// Purpose: link between the configuration memory and the target configuration port
// Assumes: open-drain and tri-state lines resolved here from enables
// Notes: pull-ups modelled for the shared reset line and config pulse
interface cprc_if;
   import cprc_pkg::*;
   // ---------------------------------------------------------------
   // driver signals
   // ---------------------------------------------------------------
   logic oer_dev_oe; // device pulls shared reset line low
   logic oer_tgt_oe; // target start gate pulls it low
   logic oer_in;
   cprc_data_t data_out;
   logic data_oe;
   cprc_data_t data_in;
   logic chain_enable_out_n;
   logic chip_enable_n;
   logic cfgp_dev_out;
   logic cfgp_dev_oe;
   logic cfgp_tgt_oe; // target side may pull pulse low (parallel variant)
   logic cfgp_in;
   logic clk_out;
   logic clk_out_oe;
   logic ext_clk; // external oscillator clock
   logic target_config_clock;
   logic busy;
   logic target_select_n;
   logic target_write_n;
   // resolved wire levels: pull-ups win when nobody drives low
   assign oer_in = !(oer_dev_oe || oer_tgt_oe);
   assign data_in = data_oe ? data_out : DATA_ZERO;
   assign cfgp_in = !((cfgp_dev_oe && !cfgp_dev_out) || cfgp_tgt_oe);
   assign target_config_clock = clk_out_oe ? clk_out : ext_clk;
   modport dev (
      output oer_dev_oe, data_out, data_oe, chain_enable_out_n,
      output cfgp_dev_out, cfgp_dev_oe, clk_out, clk_out_oe,
      input oer_in, chip_enable_n, cfgp_in, target_config_clock, busy
   );
   modport tgt (
      output oer_tgt_oe, chip_enable_n, cfgp_tgt_oe, busy,
      output target_select_n, target_write_n,
      input oer_in, data_in, chain_enable_out_n, cfgp_in, target_config_clock
   );
endinterface : cprc_if

// ### logic/cprc_dev.sv
// Purpose: configuration memory end: power-on reset, reset/deselect, address stream
// Assumes: supply monitors arrive as comparator levels; link clock sampled by MCLK
// Notes: shared reset line is open drain, only ever pulled low
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module cprc_dev #(
   parameter bit PARALLEL = 1'b1,
   parameter bit PROM_CLOCK_OUT_EN = 1'b0,
   parameter int HOLD_CYC = cprc_pkg::RELEASE_HOLD_CYC
) (
   input wire logic MCLK,
   input wire logic RSTN,
   cprc_if.dev LINK,
   input wire logic CORE_POR_OK,
   input wire logic IO_LEVEL_OK,
   input wire logic CORE_BELOW_PD,
   input wire logic CONFIG_REQ,
   input wire cprc_pkg::cprc_data_t MEM_DATA,
   output logic [cprc_pkg::ADDR_W-1:0] MEM_ADDR,
   output logic IN_RESET
);
   import cprc_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RAMP = 3'b001,
      ST_HOLD = 3'b010,
      ST_RUN = 3'b100
   } cprc_pst_t;
   cprc_pst_t pst_r, pst_nxt;
   logic [31:0] hold_cnt_r, hold_cnt_nxt;
   logic [2:0] clk_s_r, oer_s_r, ce_s_r, busy_s_r;
   logic clk_q_r, oer_q_r, ce_q_r, busy_q_r;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic oer_oe_r, data_oe_r, ceo_n_r, cfgp_oe_r, prom_clock_out_r, prom_clock_out_oe_r;
   cprc_data_t data_r;
   logic [7:0] div_r;
   logic [7:0] pulse_r;
   logic [ADDR_W-1:0] addr_out_r;
   logic in_reset_r;
   logic load_r; // memory word at the new address is ready one edge later

   // ---------------------------------------------------------------
   // power good decode
   // ---------------------------------------------------------------
   // serial variant ignores the io supply entirely
   wire logic supplies_ok = CORE_POR_OK && (!PARALLEL || IO_LEVEL_OK);
   wire logic brown_out = CORE_BELOW_PD || !supplies_ok;

   // power sequencer
   always_comb begin
      pst_nxt = pst_r;
      hold_cnt_nxt = hold_cnt_r;
      unique case (pst_r)
         ST_RAMP: begin
            hold_cnt_nxt = 32'h0000_0000;
            // a pending power-down level must clear too, or ramp and hold would chatter
            if (!brown_out) pst_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
            if (brown_out) pst_nxt = ST_RAMP;
            else if (hold_cnt_r >= 32'(HOLD_CYC - 1)) pst_nxt = ST_RUN;
         end
         ST_RUN: if (brown_out) pst_nxt = ST_RAMP;
      endcase
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         pst_r <= ST_RAMP;
         hold_cnt_r <= 32'h0000_0000;
      end else begin
         pst_r <= pst_nxt;
         hold_cnt_r <= hold_cnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // input synchronisers: 2nd and 3rd must agree before a change counts
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         clk_s_r <= 3'b000;
         oer_s_r <= 3'b000;
         ce_s_r <= 3'b111;
         busy_s_r <= 3'b000;
         clk_q_r <= 1'b0;
         oer_q_r <= 1'b0;
         ce_q_r <= 1'b1;
         busy_q_r <= 1'b0;
      end else begin
         clk_s_r <= {clk_s_r[1:0], LINK.target_config_clock};
         oer_s_r <= {oer_s_r[1:0], LINK.oer_in};
         ce_s_r <= {ce_s_r[1:0], LINK.chip_enable_n};
         busy_s_r <= {busy_s_r[1:0], LINK.busy};
         if (clk_s_r[1] == clk_s_r[2]) clk_q_r <= clk_s_r[2];
         if (oer_s_r[1] == oer_s_r[2]) oer_q_r <= oer_s_r[2];
         if (ce_s_r[1] == ce_s_r[2]) ce_q_r <= ce_s_r[2];
         if (busy_s_r[1] == busy_s_r[2]) busy_q_r <= busy_s_r[2];
      end
   end

   // ---------------------------------------------------------------
   // reset decode and address counter
   // ---------------------------------------------------------------
   // line low (ours or anyone's) or deselect puts the stream in reset
   wire logic powered = (pst_r == ST_RUN);
   wire logic stream_rst = !powered || !oer_q_r || ce_q_r;
   wire logic clk_rise = (clk_s_r[1] == clk_s_r[2]) && clk_s_r[2] && !clk_q_r;
   wire logic stalled = PARALLEL && busy_q_r;
   wire logic at_tc = (addr_r == TERM_COUNT);
   wire logic advance = !stream_rst && clk_rise && !stalled && !at_tc;

   always_comb begin
      addr_nxt = addr_r;
      if (stream_rst) addr_nxt = ADDR_ZERO;
      else if (advance) addr_nxt = addr_r + ADDR_ONE;
   end

   // outputs registered; at terminal count data floats and chain goes low
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         addr_r <= ADDR_ZERO;
         addr_out_r <= ADDR_ZERO;
         data_r <= DATA_ZERO;
         data_oe_r <= 1'b0;
         ceo_n_r <= 1'b1;
         oer_oe_r <= 1'b1;
         in_reset_r <= 1'b1;
         load_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         addr_out_r <= addr_nxt;
         load_r <= advance || stream_rst;
         if (load_r) data_r <= MEM_DATA;
         data_oe_r <= !stream_rst && !at_tc;
         ceo_n_r <= stream_rst || !at_tc;
         oer_oe_r <= !powered;
         in_reset_r <= stream_rst;
      end
   end

   // ---------------------------------------------------------------
   // config pulse and clock output
   // ---------------------------------------------------------------
   // pulse low once on request; never read back here, only the parallel target also pulls it low
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         pulse_r <= 8'h00;
         cfgp_oe_r <= 1'b0;
      end else begin
         if (CONFIG_REQ && pulse_r == 8'h00 && powered) pulse_r <= 8'(CFG_PULSE_CYC);
         else if (pulse_r != 8'h00) pulse_r <= pulse_r - 8'h01;
         cfgp_oe_r <= (CONFIG_REQ && powered) || pulse_r > 8'h01;
      end
   end

   // divider for prom_clock_out, parallel variant only, tristated in reset
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         div_r <= 8'h00;
         prom_clock_out_r <= 1'b0;
         prom_clock_out_oe_r <= 1'b0;
      end else begin
         div_r <= (div_r >= 8'(CLK_DIV_HALF - 1)) ? 8'h00 : div_r + 8'h01;
         if (div_r >= 8'(CLK_DIV_HALF - 1)) prom_clock_out_r <= !prom_clock_out_r;
         prom_clock_out_oe_r <= PARALLEL && PROM_CLOCK_OUT_EN && !stream_rst && !at_tc;
      end
   end

   assign LINK.oer_dev_oe = oer_oe_r;
   assign LINK.data_out = data_r;
   assign LINK.data_oe = data_oe_r;
   assign LINK.chain_enable_out_n = ceo_n_r;
   assign LINK.cfgp_dev_out = 1'b0;
   assign LINK.cfgp_dev_oe = cfgp_oe_r;
   assign LINK.clk_out = prom_clock_out_r;
   assign LINK.clk_out_oe = prom_clock_out_oe_r;
   assign MEM_ADDR = addr_out_r;
   assign IN_RESET = in_reset_r;
endmodule // cprc_dev

// ### logic/cprc_tgt.sv
// Purpose: target configuration port end: start gate, select, write, busy, byte capture
// Assumes: link clock sampled by MCLK; bench gives external clock
// Notes: start gate open drain pulls the shared reset line low
// ---------------------------------------------------------------
module cprc_tgt #(
   parameter bit PARALLEL = 1'b1
) (
   input wire logic MCLK,
   input wire logic RSTN,
   cprc_if.tgt LINK,
   input wire logic HOLD_INIT,
   input wire logic DESELECT,
   input wire logic BUSY_REQ,
   input wire logic PROG_REQ,
   output cprc_pkg::cprc_data_t BYTE_DATA,
   output logic BYTE_VALID,
   output logic CFG_STARTED
);
   import cprc_pkg::*;

   logic [2:0] clk_s_r, oer_s_r;
   logic clk_q_r, oer_q_r;
   logic init_oe_r, ce_n_r, busy_r, prog_oe_r, started_r, valid_r;
   cprc_data_t byte_r;

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         clk_s_r <= 3'b000;
         oer_s_r <= 3'b000;
         clk_q_r <= 1'b0;
         oer_q_r <= 1'b0;
      end else begin
         clk_s_r <= {clk_s_r[1:0], LINK.target_config_clock};
         oer_s_r <= {oer_s_r[1:0], LINK.oer_in};
         if (clk_s_r[1] == clk_s_r[2]) clk_q_r <= clk_s_r[2];
         if (oer_s_r[1] == oer_s_r[2]) oer_q_r <= oer_s_r[2];
      end
   end

   wire logic clk_rise = (clk_s_r[1] == clk_s_r[2]) && clk_s_r[2] && !clk_q_r;

   // ---------------------------------------------------------------
   // control outputs and capture; starts only once the line has risen
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         init_oe_r <= 1'b0;
         ce_n_r <= 1'b1;
         busy_r <= 1'b0;
         prog_oe_r <= 1'b0;
         started_r <= 1'b0;
         valid_r <= 1'b0;
         byte_r <= DATA_ZERO;
      end else begin
         init_oe_r <= HOLD_INIT;
         ce_n_r <= DESELECT;
         busy_r <= PARALLEL && BUSY_REQ;
         prog_oe_r <= PARALLEL && PROG_REQ;
         started_r <= oer_q_r && !ce_n_r;
         valid_r <= oer_q_r && !ce_n_r && clk_rise && !busy_r;
         if (oer_q_r && clk_rise) byte_r <= LINK.data_in;
      end
   end

   assign LINK.oer_tgt_oe = init_oe_r;
   assign LINK.chip_enable_n = ce_n_r;
   assign LINK.busy = busy_r;
   assign LINK.cfgp_tgt_oe = prog_oe_r;
   assign LINK.target_select_n = 1'b0;
   assign LINK.target_write_n = 1'b0;
   assign BYTE_DATA = byte_r;
   assign BYTE_VALID = valid_r;
   assign CFG_STARTED = started_r;
endmodule // cprc_tgt

// ### dv/cprc_sva.sv
// Purpose: property checker beside the memory-to-target link
// Assumes: parallel variant, prom clock out disabled, supplies from the bench
// Notes: one clock domain, so default clocking and disable
module cprc_sva #(
   parameter int HOLD_CYC = 10
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic CORE_POR_OK,
   input wire logic IO_LEVEL_OK,
   input wire logic CORE_BELOW_PD,
   input wire logic oer_dev_oe,
   input wire logic oer_in,
   input wire logic data_oe,
   input wire logic chain_enable_out_n,
   input wire logic chip_enable_n,
   input wire logic cfgp_dev_oe,
   input wire logic clk_out_oe
);
   import cprc_pkg::*;
   // ----
   // helpers
   // ----
   // parallel variant needs io supply as well as core
   wire sup_ok = CORE_POR_OK && IO_LEVEL_OK && !CORE_BELOW_PD;
   int ok_cnt_r;
   int pulse_cnt_r;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   // run length of good supplies and of the config pulse
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         ok_cnt_r <= 0;
         pulse_cnt_r <= 0;
      end else begin
         ok_cnt_r <= sup_ok ? ok_cnt_r + 1 : 0;
         pulse_cnt_r <= cfgp_dev_oe ? pulse_cnt_r + 1 : 0;
      end
   end
   // ----
   // properties
   // ----
   property p_ramp_hold; !sup_ok [*3] |-> oer_dev_oe; endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("line free while ramping");
   property p_release; $fell(oer_dev_oe) |-> ok_cnt_r >= HOLD_CYC; endproperty
   a_release: assert property (p_release) else $error("line released early");
   property p_brown_out; $fell(sup_ok) |-> ##[1:2] oer_dev_oe; endproperty
   a_brown_out: assert property (p_brown_out) else $error("no reset on brown-out");
   property p_polarity; oer_dev_oe |-> !oer_in; endproperty
   a_polarity: assert property (p_polarity) else $error("shared line not low");
   property p_line_reset; !oer_in [*6] |-> !data_oe && chain_enable_out_n; endproperty
   a_line_reset: assert property (p_line_reset) else $error("outputs live in reset");
   property p_deselect;
      chip_enable_n [*6] |-> !data_oe && chain_enable_out_n && !clk_out_oe;
   endproperty
   a_deselect: assert property (p_deselect) else $error("outputs live deselected");
   property p_term; !chain_enable_out_n |-> !data_oe; endproperty
   a_term: assert property (p_term) else $error("data live at end");
   property p_pulse; $fell(cfgp_dev_oe) |-> pulse_cnt_r == CFG_PULSE_CYC; endproperty
   a_pulse: assert property (p_pulse) else $error("config pulse length wrong");
   property p_clk_ext; !clk_out_oe; endproperty
   a_clk_ext: assert property (p_clk_ext) else $error("clock out driven");
   c_release: cover property ($fell(oer_dev_oe));
   c_pulse: cover property ($fell(cfgp_dev_oe));
   c_float: cover property (data_oe ##1 !data_oe);
endmodule // cprc_sva

// ### dv/config_prom_reset_control_test.sv
// Purpose: self-checking bench joining both ends of the link
// Assumes: bench makes the external link clock, 160 ns period
// Notes: hold delay shortened; terminal count left to the checker
module config_prom_reset_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cprc_pkg::*;
   localparam int HOLD = 10;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic core_ok = 1'b0;
   logic io_ok = 1'b0;
   logic below_pd = 1'b0;
   logic cfg_req = 1'b0;
   logic hold_init = 1'b0;
   logic deselect = 1'b0;
   logic busy_req = 1'b0;
   logic prog_req = 1'b0;
   logic [ADDR_W-1:0] mem_addr;
   cprc_data_t mem_data;
   cprc_data_t byte_data;
   logic byte_valid;
   logic in_reset;
   logic cfg_started;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int valid_cnt = 0;
   // ----
   // structure
   // ----
   cprc_if cprc_if_i ();
   // bench memory: content tied to its address
   assign mem_data = mem_addr[7:0] ^ 8'hA5;
   cprc_dev #(.PARALLEL(1'b1), .PROM_CLOCK_OUT_EN(1'b0), .HOLD_CYC(HOLD)) cprc_dev_i (
      .MCLK(mclk), .RSTN(rstn), .LINK(cprc_if_i), .CORE_POR_OK(core_ok),
      .IO_LEVEL_OK(io_ok), .CORE_BELOW_PD(below_pd), .CONFIG_REQ(cfg_req),
      .MEM_DATA(mem_data), .MEM_ADDR(mem_addr), .IN_RESET(in_reset));
   cprc_tgt #(.PARALLEL(1'b1)) cprc_tgt_i (
      .MCLK(mclk), .RSTN(rstn), .LINK(cprc_if_i), .HOLD_INIT(hold_init),
      .DESELECT(deselect), .BUSY_REQ(busy_req), .PROG_REQ(prog_req),
      .BYTE_DATA(byte_data), .BYTE_VALID(byte_valid), .CFG_STARTED(cfg_started));
   cprc_sva #(.HOLD_CYC(HOLD)) cprc_sva_i (
      .MCLK(mclk), .RSTN(rstn), .CORE_POR_OK(core_ok), .IO_LEVEL_OK(io_ok),
      .CORE_BELOW_PD(below_pd), .oer_dev_oe(cprc_if_i.oer_dev_oe),
      .oer_in(cprc_if_i.oer_in), .data_oe(cprc_if_i.data_oe),
      .chain_enable_out_n(cprc_if_i.chain_enable_out_n),
      .chip_enable_n(cprc_if_i.chip_enable_n), .cfgp_dev_oe(cprc_if_i.cfgp_dev_oe),
      .clk_out_oe(cprc_if_i.clk_out_oe));
   // ----
   // shared tasks
   // ----
   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // link clock only runs within a burst; 8 cycles each phase
   task automatic clk_pulses(input int n);
      repeat (n) begin
         cprc_if_i.ext_clk = 1'b1;
         step(8);
         cprc_if_i.ext_clk = 1'b0;
         step(8);
      end
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_power_up();
      core_ok = 1'b1;
      step(3 * HOLD);
      check(cprc_if_i.oer_in, 1'b0);
      check(cfg_started, 1'b0);
      check(cprc_if_i.target_select_n, 1'b0);
      check(cprc_if_i.target_write_n, 1'b0);
      io_ok = 1'b1;
      step(HOLD);
      check(cprc_if_i.oer_in, 1'b0);
      step(6);
      check(cprc_if_i.oer_in, 1'b1);
      step(4);
      check(cfg_started, 1'b1);
   endtask
   task automatic t_stream();
      int v0;
      v0 = valid_cnt;
      check(mem_addr, 32'h0);
      clk_pulses(3);
      check(mem_addr, 32'h3);
      check(cprc_if_i.data_in, 8'h03 ^ 8'hA5);
      check(byte_data, 8'h02 ^ 8'hA5);
      check(cprc_if_i.chain_enable_out_n, 1'b1);
      busy_req = 1'b1;
      // let busy cross the synchronisers before the next clock rise
      step(8);
      clk_pulses(2);
      check(mem_addr, 32'h3);
      busy_req = 1'b0;
      step(8);
      clk_pulses(1);
      check(mem_addr, 32'h4);
      check(valid_cnt - v0, 4);
   endtask
   // line held low by the target, or chip deselected
   task automatic t_reset_src(input logic use_desel);
      clk_pulses(2);
      hold_init = !use_desel;
      deselect = use_desel;
      step(8);
      check(cprc_if_i.oer_dev_oe, 1'b0);
      check(mem_addr, 32'h0);
      check(cprc_if_i.data_in, 32'h0);
      check(in_reset, 1'b1);
      clk_pulses(1);
      check(mem_addr, 32'h0);
      hold_init = 1'b0;
      deselect = 1'b0;
      step(8);
      check(cprc_if_i.oer_in, 1'b1);
      clk_pulses(1);
      check(mem_addr, 32'h1);
   endtask
   task automatic t_brown_out();
      below_pd = 1'b1;
      step(3);
      check(cprc_if_i.oer_dev_oe, 1'b1);
      below_pd = 1'b0;
      step(HOLD);
      check(cprc_if_i.oer_in, 1'b0);
      step(6);
      check(cprc_if_i.oer_in, 1'b1);
      check(mem_addr, 32'h0);
   endtask
   task automatic t_cfg_pulse();
      int low_cnt;
      low_cnt = 0;
      cfg_req = 1'b1;
      step(1);
      cfg_req = 1'b0;
      for (int i = 0; i < 60; i++) begin
         low_cnt += (cprc_if_i.cfgp_in === 1'b0);
         step(1);
      end
      check(low_cnt, CFG_PULSE_CYC);
      prog_req = 1'b1;
      step(3);
      check(cprc_if_i.cfgp_in, 1'b0);
      prog_req = 1'b0;
      step(3);
   endtask
   // ----
   // run
   // ----
   // main sequence
   initial begin
      cprc_if_i.ext_clk = 1'b0;
      step(5);
      rstn = 1'b1;
      t_power_up();
      t_stream();
      t_reset_src(1'b0);
      t_reset_src(1'b1);
      t_brown_out();
      t_cfg_pulse();
      close_out();
   end
   // clock
   always #5 mclk = ~mclk;
   // accepted bytes counted on the falling edge, clear of the launch edge
   always @(negedge mclk) begin
      if (byte_valid === 1'b1) valid_cnt++;
   end
   // hang guard: whole run needs about 410 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         close_out();
      end
   end
endmodule // config_prom_reset_control_test
